// ---- rcsc_pkg.sv ----
// constants shared by the reset and clock system control block
package rcsc_pkg;

  // ==========================================================================
  // special function register addresses
  localparam logic [7:0] ADDR_OPTION = 8'h94;
  localparam logic [7:0] ADDR_FLAGS  = 8'h95;
  localparam logic [7:0] ADDR_CMD    = 8'h97;
  localparam logic [7:0] ADDR_CLKCTL = 8'hd8;
  localparam logic [7:0] ADDR_TRIM   = 8'hf6;
  localparam logic [7:0] ADDR_PWRWDT = 8'hf7;
  localparam logic [7:0] ADDR_CLRSTB = 8'hf8;

  // ==========================================================================
  // configuration word locations in program memory
  localparam logic [12:0] CFG_LOW_ADDR  = 13'h1ffd;
  localparam logic [12:0] CFG_HIGH_ADDR = 13'h1fff;

  // ==========================================================================
  // reset values and codes
  localparam logic [7:0] OPTION_RST    = 8'h00;
  localparam logic [7:0] CLKCTL_RST    = 8'h03;
  localparam logic [7:0] CLKCTL_WMASK  = 8'hdf;
  localparam logic [3:0] PWRWDT_RST    = 4'h0;
  localparam logic [7:0] SW_RESET_CODE = 8'h56;

  // threshold select codes
  localparam logic [1:0] LV_3V5 = 2'b00;
  localparam logic [1:0] LV_2V7 = 2'b01;
  localparam logic [1:0] LV_4V1 = 2'b10;
  localparam logic [1:0] LV_2V3 = 2'b11;

  // watchdog control: upper bit enables, both bits keep it alive in idle/stop
  localparam logic [1:0] WDT_ALWAYS = 2'b11;

  // ==========================================================================
  // timing
  localparam int CLK_HZ     = 40000000;
  localparam int SLOW_RC_HZ = 68000;
  localparam int WARM_MS    = 40;
  localparam int WARM_CYC   = WARM_MS * (CLK_HZ / 1000);
  localparam int WDT_MS_00  = 480;
  localparam int WDT_MS_01  = 240;
  localparam int WDT_MS_10  = 120;
  localparam int WDT_MS_11  = 60;
  localparam int WDT_TK_00  = WDT_MS_00 * SLOW_RC_HZ / 1000;
  localparam int WDT_TK_01  = WDT_MS_01 * SLOW_RC_HZ / 1000;
  localparam int WDT_TK_10  = WDT_MS_10 * SLOW_RC_HZ / 1000;
  localparam int WDT_TK_11  = WDT_MS_11 * SLOW_RC_HZ / 1000;
  localparam logic [1:0] PIN_TICKS = 2'd2;

  typedef enum logic [2:0] {
    ST_WARM = 3'b000,
    ST_LDLO = 3'b001,
    ST_LDHI = 3'b010,
    ST_RST  = 3'b011,
    ST_RUN  = 3'b100
  } rcsc_state_t;

endpackage

// ---- rcsc_top.sv ----
// reset sources, low-voltage, watchdog and system clock control
//
// Contract
// - threshold field: 00 3.5V, 01 2.7V, 10 4.1V, 11 2.3V plus 2.7V detect.
// - detect flag only valid at the lowest threshold, otherwise reads zero.
// - power-saving forces 2.3V in idle; stop with it, or code 11, disables.
// - power-on holds reset 40 ms, then loads configuration words.
// - every reset cause returns the registers to defaults.
// - pin reset is active low, seen after two slow RC cycles low.
// - configuration bit enables the external reset pin.
// - writing 56h to 97h resets the device.
// - watchdog counts slow RC ticks, cleared by reset or clear bit.
// - watchdog period field: 480, 240, 120, 60 ms.
// - watchdog control: 0x off, 10 run modes only, 11 always.
// - watchdog clear bit restarts count and self-clears next cycle.
// - detect flag follows low supply, inactive in stop mode.
// - after reset the clock is the slow internal RC.
// - clock prescaler divides 1, 2, 4, 16; resets to 11.
// - fast from crystal or RC/2, slow from 32 KHz crystal or RC.
// - illegal clock control writes are rejected per bit.
// - seven-bit fast RC trim, loaded from configuration.
// - slow type 0 RC, 1 crystal; writable only on fast clock.
// - prescaler codes: 00 /16, 01 /4, 10 /2, 11 /1.
// - stop bit changes in slow only; select changes only when stop is 0.
// - fast type 0 internal RC, 1 crystal.
`timescale 1ns/1ps

module rcsc_top #(
  parameter int WARM_CYCLES = rcsc_pkg::WARM_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_rd,
  output logic      [7:0]  sfr_rdata,
  input  wire logic        src_tick,
  input  wire logic        ext_reset_n,
  input  wire logic [3:0]  vdd_below,
  input  wire logic        idle_mode,
  input  wire logic        stop_mode,
  output logic             cfg_rd_en,
  output logic      [12:0] cfg_rd_addr,
  input  wire logic [7:0]  cfg_rd_data,
  output logic             sys_reset_n,
  output logic             slow_clock_type,
  output logic             fast_clock_type,
  output logic             peripheral_clock_stop,
  output logic             fast_clock_stop,
  output logic             fast_clock_select,
  output logic      [1:0]  clock_prescaler,
  output logic      [6:0]  fast_rc_trim,
  output logic             low_voltage_reset,
  output logic      [1:0]  reset_level,
  output logic             low_voltage_detect
);

  // ==========================================================================
  // state
  rcsc_pkg::rcsc_state_t st, next_st;
  logic [20:0] warm_cnt, next_warm_cnt;
  logic [6:0]  cfg_low, next_cfg_low;
  logic [7:0]  cfg_high, next_cfg_high;
  logic [7:0]  opt, next_opt;
  logic [3:0]  pwr, next_pwr;
  logic        clr, next_clr;
  logic [7:0]  system_clock_control, next_system_clock_control;
  logic [6:0]  trim, next_trim;
  logic [15:0] wdt, next_wdt;
  logic [1:0]  xcnt, next_xcnt;
  logic        det_flag, next_det_flag;
  logic        lv_arm, next_lv_arm;
  logic [1:0]  lvl, next_lvl;
  logic [7:0]  rdata, next_rdata;
  logic        rd_en, next_rd_en;
  logic [12:0] rd_addr, next_rd_addr;
  logic        rst_out, next_rst_out;
  logic        any_rst;
  logic        wdt_run;
  logic        sw_hit;
  logic [15:0] wdt_lim;
  logic [1:0]  thr_code;

  assign thr_code = cfg_high[5:4];

  // ==========================================================================
  // watchdog period
  always_comb begin
    unique case (opt[5:4])
      2'b00: wdt_lim = 16'(rcsc_pkg::WDT_TK_00);
      2'b01: wdt_lim = 16'(rcsc_pkg::WDT_TK_01);
      2'b10: wdt_lim = 16'(rcsc_pkg::WDT_TK_10);
      2'b11: wdt_lim = 16'(rcsc_pkg::WDT_TK_11);
    endcase
  end

  // ==========================================================================
  // next-state logic
  always_comb begin
    logic wr;
    wr            = sfr_wr && st == rcsc_pkg::ST_RUN;
    next_st       = st;
    next_warm_cnt = warm_cnt;
    next_cfg_low  = cfg_low;
    next_cfg_high = cfg_high;
    next_opt      = opt;
    next_pwr      = pwr;
    next_clr      = 1'b0;
    next_system_clock_control   = system_clock_control;
    next_trim     = trim;
    next_wdt      = wdt;
    next_rd_en    = 1'b0;
    next_rd_addr  = rd_addr;
    next_rst_out  = 1'b1;
    // 11 keeps the count alive in idle/stop; otherwise it pauses there
    wdt_run = !(idle_mode || stop_mode) || pwr[3:2] == rcsc_pkg::WDT_ALWAYS;
    sw_hit  = wr && sfr_addr == rcsc_pkg::ADDR_CMD
              && sfr_wdata == rcsc_pkg::SW_RESET_CODE;

    // pin filter: consecutive slow RC ticks seen low, saturating
    if (ext_reset_n || !cfg_high[6]) begin
      next_xcnt = 2'd0;
    end else if (src_tick && xcnt != rcsc_pkg::PIN_TICKS) begin
      next_xcnt = xcnt + 2'd1;
    end else begin
      next_xcnt = xcnt;
    end

    // threshold in effect for the current operating mode
    next_lvl    = thr_code;
    next_lv_arm = 1'b1;
    if (stop_mode && (pwr[1] || thr_code == rcsc_pkg::LV_2V3)) begin
      next_lv_arm = 1'b0;
    end else if (idle_mode && pwr[1]) begin
      next_lvl = rcsc_pkg::LV_2V3;
    end
    // detector sits at the 2.7V comparator, usable only with 2.3V reset
    next_det_flag = thr_code == rcsc_pkg::LV_2V3 && !stop_mode
               && vdd_below[rcsc_pkg::LV_2V7];

    any_rst = 1'b0;
    if (st == rcsc_pkg::ST_RUN) begin
      if (sw_hit || xcnt == rcsc_pkg::PIN_TICKS || (lv_arm && vdd_below[lvl])) begin
        any_rst = 1'b1;
      end
      if (clr) begin
        next_wdt = 16'd0;
      end else if (src_tick && wdt_run) begin
        if (wdt == wdt_lim - 16'd1) begin
          next_wdt = 16'd0;
          if (pwr[3]) begin
            any_rst = 1'b1;
          end
        end else begin
          next_wdt = wdt + 16'd1;
        end
      end
    end

    unique case (st)
      rcsc_pkg::ST_WARM: begin
        next_rst_out  = 1'b0;
        next_warm_cnt = warm_cnt + 21'd1;
        if (warm_cnt == 21'(WARM_CYCLES - 1)) begin
          next_st      = rcsc_pkg::ST_LDLO;
          next_rd_en   = 1'b1;
          next_rd_addr = rcsc_pkg::CFG_LOW_ADDR;
        end
      end
      rcsc_pkg::ST_LDLO: begin
        next_rst_out = 1'b0;
        next_st      = rcsc_pkg::ST_LDHI;
        next_rd_en   = 1'b1;
        next_rd_addr = rcsc_pkg::CFG_HIGH_ADDR;
        next_cfg_low = cfg_rd_data[6:0];
      end
      rcsc_pkg::ST_LDHI: begin
        next_rst_out  = 1'b0;
        next_st       = rcsc_pkg::ST_RST;
        next_cfg_high = cfg_rd_data;
      end
      rcsc_pkg::ST_RST: begin
        // defaults; configuration words survive every reset but power-on
        next_st     = rcsc_pkg::ST_RUN;
        next_opt    = rcsc_pkg::OPTION_RST;
        next_pwr    = rcsc_pkg::PWRWDT_RST;
        next_system_clock_control = rcsc_pkg::CLKCTL_RST;
        next_trim   = cfg_low;
        next_wdt    = 16'd0;
      end
      rcsc_pkg::ST_RUN: begin
        if (any_rst) begin
          next_st      = rcsc_pkg::ST_RST;
          next_rst_out = 1'b0;
        end else if (wr) begin
          unique case (sfr_addr)
            rcsc_pkg::ADDR_OPTION: next_opt  = sfr_wdata;
            rcsc_pkg::ADDR_PWRWDT: next_pwr  = sfr_wdata[7:4];
            rcsc_pkg::ADDR_CLRSTB: next_clr  = sfr_wdata[7];
            rcsc_pkg::ADDR_TRIM:   next_trim = sfr_wdata[6:0];
            rcsc_pkg::ADDR_CLKCTL: begin
              next_system_clock_control[4]   = sfr_wdata[4];
              next_system_clock_control[1:0] = sfr_wdata[1:0];
              if (system_clock_control[2]) begin
                next_system_clock_control[7] = sfr_wdata[7];
              end else begin
                next_system_clock_control[6] = sfr_wdata[6];
                next_system_clock_control[3] = sfr_wdata[3];
              end
              if (!system_clock_control[3]) begin
                next_system_clock_control[2] = sfr_wdata[2];
              end
              // never let stop and select stand together
              if (next_system_clock_control[3] && next_system_clock_control[2]) begin
                next_system_clock_control[2] = system_clock_control[2];
              end
              next_system_clock_control = next_system_clock_control & rcsc_pkg::CLKCTL_WMASK;
            end
            default: ;
          endcase
        end
      end
      default: begin
        next_st = rcsc_pkg::ST_RST;
      end
    endcase

    // read path; the command register is write-only and reads zero
    next_rdata = rdata;
    if (sfr_rd) begin
      unique case (sfr_addr)
        rcsc_pkg::ADDR_OPTION: next_rdata = opt;
        rcsc_pkg::ADDR_FLAGS:  next_rdata = {det_flag, 7'h00};
        rcsc_pkg::ADDR_CLKCTL: next_rdata = system_clock_control;
        rcsc_pkg::ADDR_TRIM:   next_rdata = {1'b0, trim};
        rcsc_pkg::ADDR_PWRWDT: next_rdata = {pwr, 4'h0};
        rcsc_pkg::ADDR_CLRSTB: next_rdata = {clr, 7'h00};
        default:               next_rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st       <= rcsc_pkg::ST_WARM;
      warm_cnt <= 21'd0;
      cfg_low  <= 7'h00;
      cfg_high <= 8'h00;
      opt      <= rcsc_pkg::OPTION_RST;
      pwr      <= rcsc_pkg::PWRWDT_RST;
      clr      <= 1'b0;
      system_clock_control   <= rcsc_pkg::CLKCTL_RST;
      trim     <= 7'h00;
      wdt      <= 16'd0;
      xcnt     <= 2'd0;
      det_flag <= 1'b0;
      lv_arm   <= 1'b1;
      lvl      <= rcsc_pkg::LV_3V5;
      rdata    <= 8'h00;
      rd_en    <= 1'b0;
      rd_addr  <= 13'h0000;
      rst_out  <= 1'b0;
    end else begin
      st       <= next_st;
      warm_cnt <= next_warm_cnt;
      cfg_low  <= next_cfg_low;
      cfg_high <= next_cfg_high;
      opt      <= next_opt;
      pwr      <= next_pwr;
      clr      <= next_clr;
      system_clock_control   <= next_system_clock_control;
      trim     <= next_trim;
      wdt      <= next_wdt;
      xcnt     <= next_xcnt;
      det_flag <= next_det_flag;
      lv_arm   <= next_lv_arm;
      lvl      <= next_lvl;
      rdata    <= next_rdata;
      rd_en    <= next_rd_en;
      rd_addr  <= next_rd_addr;
      rst_out  <= next_rst_out;
    end
  end

  assign sfr_rdata             = rdata;
  assign cfg_rd_en             = rd_en;
  assign cfg_rd_addr           = rd_addr;
  assign sys_reset_n           = rst_out;
  assign slow_clock_type       = system_clock_control[7];
  assign fast_clock_type       = system_clock_control[6];
  assign peripheral_clock_stop = system_clock_control[4];
  assign fast_clock_stop       = system_clock_control[3];
  assign fast_clock_select     = system_clock_control[2];
  assign clock_prescaler       = system_clock_control[1:0];
  assign fast_rc_trim          = trim;
  assign low_voltage_reset     = lv_arm;
  assign reset_level           = lvl;
  assign low_voltage_detect    = det_flag;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence load_seq;
    st == rcsc_pkg::ST_LDLO ##1 st == rcsc_pkg::ST_LDHI ##1 st == rcsc_pkg::ST_RST;
  endsequence

  sequence sw_write_seq;
    st == rcsc_pkg::ST_RUN && sfr_wr && sfr_addr == rcsc_pkg::ADDR_CMD;
  endsequence

  warm_load_a: assert property (
    st == rcsc_pkg::ST_WARM && warm_cnt == 21'(WARM_CYCLES - 1) |=> load_seq)
    else $error("config load did not follow warm-up");
  sw_rst_a: assert property (
    sw_write_seq ##0 sfr_wdata == rcsc_pkg::SW_RESET_CODE
    |=> !sys_reset_n ##1 system_clock_control == rcsc_pkg::CLKCTL_RST)
    else $error("software reset code did not reset");
  sw_nop_a: assert property (
    sw_write_seq ##0 (sfr_wdata != rcsc_pkg::SW_RESET_CODE && !any_rst) |=> sys_reset_n)
    else $error("other command value caused reset");
  clr_auto_a: assert property (
    clr |=> !clr && wdt == 16'd0)
    else $error("watchdog clear bit did not self-clear");
  det_gate_a: assert property (
    thr_code != rcsc_pkg::LV_2V3 || $past(stop_mode) |-> !low_voltage_detect)
    else $error("detect flag active when unusable");
  psc_reset_a: assert property (
    st == rcsc_pkg::ST_RST |=> clock_prescaler == 2'b11 && !fast_clock_select)
    else $error("clock control not at default after reset");
  sel_guard_a: assert property (
    st == rcsc_pkg::ST_RUN && fast_clock_stop |=> $stable(fast_clock_select))
    else $error("select changed while fast clock stopped");
  no_both_a: assert property (
    !(fast_clock_stop && fast_clock_select))
    else $error("stop and select both set");
  pin_rst_a: assert property (
    st == rcsc_pkg::ST_RUN && xcnt == rcsc_pkg::PIN_TICKS |=> st == rcsc_pkg::ST_RST)
    else $error("filtered pin reset ignored");
  idle_lvl_a: assert property (
    idle_mode && !stop_mode && pwr[1] |=> reset_level == rcsc_pkg::LV_2V3 && low_voltage_reset)
    else $error("idle power-saving threshold wrong");

endmodule

// ---- reset_clock_system_control_test.sv ----
// self-checking bench for the reset and clock system control block
`timescale 1ns/1ps

module reset_clock_system_control_test;
  // ==========================================================================
  // stimulus signals
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic        sfr_wr = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_rdata;
  logic        src_tick = 1'b0;
  logic        ext_reset_n = 1'b1;
  logic [3:0]  vdd_below = 4'h0;
  logic        idle_mode = 1'b0;
  logic        stop_mode = 1'b0;
  logic        cfg_rd_en;
  logic [12:0] cfg_rd_addr;
  logic [7:0]  cfg_rd_data = 8'h00;
  logic        sys_reset_n, slow_clock_type, fast_clock_type, peripheral_clock_stop;
  logic        fast_clock_stop, fast_clock_select, low_voltage_reset, low_voltage_detect;
  logic [1:0]  clock_prescaler, reset_level;
  bit          wr_gap = 1'b0;
  logic [6:0]  fast_rc_trim;
  logic [6:0]  trim;
  logic [7:0]  cfg_high;
  logic [7:0]  exp_q[$];
  string       name_q[$];
  logic        rd_seen = 1'b0;
  int          mismatches = 0;
  int          samples_checked = 0;
  localparam int WARM = 20;

  rcsc_top #(.WARM_CYCLES(WARM)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .src_tick(src_tick),
    .ext_reset_n(ext_reset_n), .vdd_below(vdd_below), .idle_mode(idle_mode),
    .stop_mode(stop_mode), .cfg_rd_en(cfg_rd_en), .cfg_rd_addr(cfg_rd_addr),
    .cfg_rd_data(cfg_rd_data), .sys_reset_n(sys_reset_n),
    .slow_clock_type(slow_clock_type), .fast_clock_type(fast_clock_type),
    .peripheral_clock_stop(peripheral_clock_stop), .fast_clock_stop(fast_clock_stop),
    .fast_clock_select(fast_clock_select), .clock_prescaler(clock_prescaler),
    .fast_rc_trim(fast_rc_trim), .low_voltage_reset(low_voltage_reset),
    .reset_level(reset_level), .low_voltage_detect(low_voltage_detect));

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // program memory: data stands before the edge that follows the request
  always @(posedge clk_sys) begin
    #1;
    if (cfg_rd_en === 1'b1) begin
      cfg_rd_data = (cfg_rd_addr === rcsc_pkg::CFG_LOW_ADDR) ? {1'b0, trim} : cfg_high;
    end
  end

  // ==========================================================================
  // read monitor: data is valid one edge after the strobe edge
  always @(posedge clk_sys) begin
    if (rd_seen) begin
      samples_checked++;
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("Error read expected none seen %h", sfr_rdata);
      end else if (sfr_rdata !== exp_q[0]) begin
        mismatches++;
        $display("Error %s expected %h seen %h", name_q[0], exp_q[0], sfr_rdata);
      end
      if (exp_q.size() != 0) begin
        void'(exp_q.pop_front());
        void'(name_q.pop_front());
      end
    end
    rd_seen <= sfr_rd;
  end

  // ==========================================================================
  // tasks
  task automatic cyc(input int n);
    wr_gap = 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input string nm, input logic [12:0] ex, input logic [12:0] got);
    samples_checked++;
    if (got !== ex) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // a write straight after a write lets one edge pass with the strobe low
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (wr_gap) cyc(1);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
    wr_gap = 1'b1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ex, input string nm);
    exp_q.push_back(ex);
    name_q.push_back(nm);
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc(1);
    sfr_rd = 1'b0;
    cyc(1);
  endtask

  // counts cycles until the device reset output falls, bounded
  task automatic until_reset(input int maxc, output int n);
    n = 0;
    while (sys_reset_n === 1'b1 && n < maxc) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic wait_up();
    int k;
    k = 0;
    while (sys_reset_n !== 1'b1 && k < 100) begin
      cyc(1);
      k++;
    end
    chk("reset release", 13'h1, {12'h0, sys_reset_n});
  endtask

  task automatic defaults();
    rd(rcsc_pkg::ADDR_CLKCTL, rcsc_pkg::CLKCTL_RST, "clock control");
    rd(rcsc_pkg::ADDR_OPTION, 8'h00, "option");
    rd(rcsc_pkg::ADDR_PWRWDT, 8'h00, "power watchdog");
    rd(rcsc_pkg::ADDR_TRIM, {1'b0, trim}, "trim");
  endtask

  task automatic power_on(input logic [7:0] hi);
    int n;
    bit first;
    cfg_high = hi;
    rst_n = 1'b0;
    cyc(8);
    rst_n = 1'b1;
    n = 0;
    first = 1'b1;
    while (sys_reset_n !== 1'b1 && n < 100) begin
      if (cfg_rd_en === 1'b1 && first) begin
        chk("first fetch", rcsc_pkg::CFG_LOW_ADDR, cfg_rd_addr);
        first = 1'b0;
      end
      cyc(1);
      n++;
    end
    chk("warm-up long enough", 13'h1, {12'h0, n >= WARM});
    chk("reset level", {11'h0, hi[5:4]}, {11'h0, reset_level});
    chk("trim out", {6'h0, trim}, {6'h0, fast_rc_trim});
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #(25 * 70000);
    mismatches++;
    final_report();
  end

  // ==========================================================================
  // main sequence
  logic [7:0] cw[9] = '{8'h41, 8'hc1, 8'h45, 8'h8d, 8'hc1, 8'hc9, 8'hcd, 8'hf2, 8'hc8};
  logic [7:0] ce[9] = '{8'h41, 8'h41, 8'h45, 8'hc5, 8'hc1, 8'hc9, 8'hc9, 8'hd2, 8'hc8};
  logic [7:0] v;
  int n;

  initial begin
    void'($urandom(5600));
    trim = 7'($urandom());
    cfg_high = 8'h70;
    power_on(8'h70);
    defaults();
    rd(8'h80, 8'h00, "unmapped");
    rd(rcsc_pkg::ADDR_CMD, 8'h00, "command read");
    v = 8'($urandom());
    wr(rcsc_pkg::ADDR_OPTION, v);
    rd(rcsc_pkg::ADDR_OPTION, v, "option rw");
    // clock control gating, one legal or illegal write per row
    cyc(1);
    for (int i = 0; i < 9; i++) begin
      wr(rcsc_pkg::ADDR_CLKCTL, cw[i]);
      rd(rcsc_pkg::ADDR_CLKCTL, ce[i], "clock gate");
    end
    chk("clock outs", 13'h0d0, {5'h0, slow_clock_type, fast_clock_type, peripheral_clock_stop,
        fast_clock_stop, fast_clock_select, 1'b0, clock_prescaler});
    // command register: other codes do nothing
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom());
      if (v == rcsc_pkg::SW_RESET_CODE) v = 8'h57;
      wr(rcsc_pkg::ADDR_CMD, v);
    end
    cyc(3);
    chk("no reset on other code", 13'h1, {12'h0, sys_reset_n});
    rd(rcsc_pkg::ADDR_CLKCTL, 8'hc8, "clock kept");
    wr(rcsc_pkg::ADDR_CMD, rcsc_pkg::SW_RESET_CODE);
    until_reset(4, n);
    chk("software reset", 13'h1, {12'h0, n < 4});
    wait_up();
    defaults();
    // detect flag at lowest threshold, off in stop
    vdd_below = 4'b0010;
    cyc(3);
    chk("detect", 13'h1, {12'h0, low_voltage_detect});
    rd(rcsc_pkg::ADDR_FLAGS, 8'h80, "flag read");
    stop_mode = 1'b1;
    cyc(3);
    chk("detect in stop", 13'h0, {12'h0, low_voltage_detect});
    chk("reset arm off in stop", 13'h0, {12'h0, low_voltage_reset});
    stop_mode = 1'b0;
    vdd_below = 4'b1010;
    until_reset(5, n);
    chk("low voltage reset", 13'h1, {12'h0, n < 5});
    vdd_below = 4'b0000;
    wait_up();
    defaults();
    // pin reset needs two slow ticks
    ext_reset_n = 1'b0;
    src_tick = 1'b1;
    cyc(1);
    src_tick = 1'b0;
    cyc(4);
    chk("pin one tick", 13'h1, {12'h0, sys_reset_n});
    src_tick = 1'b1;
    cyc(1);
    src_tick = 1'b0;
    until_reset(5, n);
    chk("pin two ticks", 13'h1, {12'h0, n < 5});
    ext_reset_n = 1'b1;
    // the pin is still seen low for a cycle after release: let it settle
    cyc(3);
    wait_up();
    // watchdog: fastest period, cleared once midway
    wr(rcsc_pkg::ADDR_OPTION, 8'h30);
    wr(rcsc_pkg::ADDR_PWRWDT, 8'h80);
    src_tick = 1'b1;
    cyc(3000);
    wr(rcsc_pkg::ADDR_CLRSTB, 8'h80);
    until_reset(4300, n);
    chk("watchdog period 11", 13'h1, {12'h0, n > 4000 && n < 4200});
    src_tick = 1'b0;
    wait_up();
    wr(rcsc_pkg::ADDR_OPTION, 8'h20);
    wr(rcsc_pkg::ADDR_PWRWDT, 8'h80);
    src_tick = 1'b1;
    until_reset(8400, n);
    chk("watchdog period 10", 13'h1, {12'h0, n > 8050 && n < 8300});
    src_tick = 1'b0;
    wait_up();
    for (int m = 0; m < 2; m++) begin
      wr(rcsc_pkg::ADDR_OPTION, 8'h30);
      wr(rcsc_pkg::ADDR_PWRWDT, m == 0 ? 8'h40 : 8'h80);
      idle_mode = (m == 1);
      src_tick = 1'b1;
      until_reset(4300, n);
      chk("watchdog held off", 13'h1, {12'h0, sys_reset_n});
      src_tick = 1'b0;
    end
    wr(rcsc_pkg::ADDR_PWRWDT, {rcsc_pkg::WDT_ALWAYS, 6'h00});
    src_tick = 1'b1;
    until_reset(4300, n);
    chk("watchdog in idle", 13'h1, {12'h0, n < 4300});
    src_tick = 1'b0;
    idle_mode = 1'b0;
    wait_up();
    // second power-on: threshold 3.5V, pin disabled
    trim = 7'($urandom());
    power_on(8'h00);
    defaults();
    vdd_below = 4'b0010;
    cyc(3);
    chk("detect unusable", 13'h0, {12'h0, low_voltage_detect});
    vdd_below = 4'b0000;
    wr(rcsc_pkg::ADDR_PWRWDT, 8'h20);
    idle_mode = 1'b1;
    cyc(3);
    chk("idle saving level", {11'h0, rcsc_pkg::LV_2V3}, {11'h0, reset_level});
    idle_mode = 1'b0;
    stop_mode = 1'b1;
    cyc(3);
    chk("stop saving off", 13'h0, {12'h0, low_voltage_reset});
    stop_mode = 1'b0;
    ext_reset_n = 1'b0;
    for (int i = 0; i < 3; i++) begin
      src_tick = 1'b1;
      cyc(1);
      src_tick = 1'b0;
      cyc(2);
    end
    chk("pin ignored", 13'h1, {12'h0, sys_reset_n});
    ext_reset_n = 1'b1;
    cyc(3);
    final_report();
  end
endmodule
